// >>> stepper_pkg.sv
// Package of shared constants for the stepper phase sequencer
package stepper_pkg;

    // Phase index width: eight half-step positions per electrical cycle
    localparam int unsigned PHASE_W = 3;
    localparam logic [2:0] PHASE_RESET = 3'h0;
    localparam logic [2:0] PHASE_ONE = 3'h1;
    localparam logic [2:0] PHASE_TWO = 3'h2;

    // Boost monostable on-time: t_on = 0.55 * R * C
    localparam real BOOST_R_OHM = 47.0;
    localparam real BOOST_C_F = 10.0e-9;
    localparam real BOOST_TON_NS = 0.55 * BOOST_R_OHM * BOOST_C_F * 1.0e9;
    localparam real CLK_PERIOD_NS = 100.0;
    localparam int unsigned BOOST_CYCLES_RAW = int'(BOOST_TON_NS / CLK_PERIOD_NS);
    localparam int unsigned BOOST_CYCLES = (BOOST_CYCLES_RAW < 1) ? 1 : BOOST_CYCLES_RAW;
    localparam int unsigned BOOST_CNT_W = 8;
    localparam logic [7:0] BOOST_LOAD = 8'(BOOST_CYCLES);
    localparam logic [7:0] BOOST_ZERO = 8'h00;
    localparam logic [7:0] BOOST_DEC = 8'h01;

    // Register map of the controller front end
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CMD = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_POS = 4'h5;

    // CTRL fields
    localparam int unsigned CTRL_HALF_BIT = 0;
    localparam int unsigned CTRL_REV_BIT = 1;
    localparam int unsigned CTRL_INH_BIT = 2;
    localparam int unsigned CTRL_BOOST_HOLD_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h4;

    // CMD fields
    localparam int unsigned CMD_STEP_BIT = 0;

    // IRQ status fields
    localparam int unsigned IRQ_STEP_BIT = 0;
    localparam int unsigned IRQ_FULL_OK_BIT = 1;
    localparam int unsigned IRQ_REFUSED_BIT = 2;
    localparam int unsigned IRQ_W = 3;

    // Step pulse width and gap in clock cycles driven on the link
    localparam logic [3:0] STEP_HIGH_CYCLES = 4'h2;
    localparam logic [3:0] STEP_LOW_CYCLES = 4'h2;

    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : stepper_pkg

// >>> stepper_link_if.sv
// Interface joining the step source and the phase sequencer
interface stepper_link_if;
    logic step;
    logic reverse;
    logic half_mode;
    logic inhibit;
    logic boost_node_o;
    logic boost_node_oe;
    logic [3:0] phase_sink_n;
    logic phase_a_boost_out;
    logic phase_b_boost_out;
    logic driver_level_sel0;
    logic driver_level_sel1;

    modport sequencer (
        input step, reverse, half_mode, inhibit, boost_node_o, boost_node_oe,
        output phase_sink_n, phase_a_boost_out, phase_b_boost_out,
        output driver_level_sel0, driver_level_sel1
    );

    modport source (
        output step, reverse, half_mode, inhibit, boost_node_o, boost_node_oe,
        input phase_sink_n, phase_a_boost_out, phase_b_boost_out,
        input driver_level_sel0, driver_level_sel1
    );
endinterface : stepper_link_if

// >>> boost_mono.sv
// Retriggerable boost monostable for one phase
module boost_mono
    import stepper_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic rstn_i, // Async reset, active low
    input wire logic trigger_i, // Phase change pulse
    input wire logic hold_i, // Timing node pulled low externally
    output logic boost_o // Boost output, active high
);

    typedef struct packed {
        logic [7:0] count;
        logic boost;
    } mono_s;

    mono_s q;
    mono_s next_q;

    always_comb begin
        next_q = q;
        if (trigger_i) begin
            next_q.count = BOOST_LOAD;
        end else if (q.count != BOOST_ZERO && !hold_i) begin
            next_q.count = q.count - BOOST_DEC;
        end
        next_q.boost = (next_q.count != BOOST_ZERO);
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign boost_o = q.boost;

endmodule : boost_mono

// >>> phase_sequencer.sv
// Phase sequencer end: step-driven Gray-coded phase logic and boost outputs
//
// Chosen here: the register offsets and the plain strobed port.
module phase_sequencer
    import stepper_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic rstn_i, // Async reset, active low
    stepper_link_if.sequencer link, // Link to step source
    output logic [2:0] position_o // Current phase index
);

    // All sequencer state except the two boost monostables lives in one register image
    typedef struct packed {
        logic step_d; // Step level one cycle ago
        logic [2:0] pos; // Half-step position index
        logic [3:0] sink_n; // Registered phase sinks, active low
        logic [1:0] zero; // Zero flags, bit 0 phase A
        logic [1:0] trig; // Boost triggers, bit 0 phase A
    } seq_s;

    seq_s q;
    seq_s next_q;
    // Per-phase views: bit 0 phase A, bit 1 phase B
    logic [1:0] boost;
    logic [1:0] ph_on;
    logic [1:0] ph_pol;
    logic [3:0] sink_next_n;
    // Position arithmetic
    logic [2:0] pos_step;
    logic [2:0] pos_new;
    logic [2:0] pos_next;
    logic take_step;
    logic hold_node;
    logic step_in;
    logic rev_in;
    logic half_in;
    logic inh_in;
    // Shared by the per-sink and per-phase loops
    genvar gi;

    // float reads high
    // An open inhibit therefore keeps the windings off, the safe default
    assign step_in = (link.step !== 1'b0);
    assign rev_in = (link.reverse !== 1'b0);
    assign half_in = (link.half_mode !== 1'b0);
    assign inh_in = (link.inhibit !== 1'b0);

    // node pulled low
    // The node only counts as held while its driver is enabled and low
    assign hold_node = (link.boost_node_oe === 1'b1) && (link.boost_node_o === 1'b0);

    // Step edge detect; step_d resets low like an idle step pin, so no edge follows reset
    // one state per rising edge
    assign take_step = step_in && !q.step_d && !inh_in;

    // Distance and direction of the next move
    always_comb begin
        if (half_in) begin
            // Half-step moves one position
            pos_step = PHASE_ONE;
        end else if (q.pos[0]) begin
            // Leaving half mode on an odd position: snap to a two-winding state
            pos_step = PHASE_ONE;
        end else begin
            // Full-step jumps over the single-winding position
            pos_step = PHASE_TWO;
        end
        if (rev_in) begin
            pos_new = q.pos - pos_step;
        end else begin
            pos_new = q.pos + pos_step;
        end
    end

    // Position after this edge; the index wraps, so eight positions form one cycle
    always_comb begin
        if (take_step) begin
            pos_next = pos_new;
        end else begin
            pos_next = q.pos;
        end
    end

    // Winding map; even positions energise two windings, odd positions one
    // Decoding the next position keeps sinks and position in the same register edge
    // single winding steps
    always_comb begin
        ph_on = 2'h3;
        ph_pol = 2'h0;
        case (pos_next)
            3'h0: begin
                // A out1 and B out1
                ph_pol = 2'h0;
            end
            3'h1: begin
                // A out2 alone
                ph_on = 2'h1;
                ph_pol = 2'h1;
            end
            3'h2: begin
                // A out2 and B out1
                ph_pol = 2'h1;
            end
            3'h3: begin
                // B out2 alone
                ph_on = 2'h2;
                ph_pol = 2'h2;
            end
            3'h4: begin
                // A out2 and B out2
                ph_pol = 2'h3;
            end
            3'h5: begin
                // A out1 alone
                ph_on = 2'h1;
                ph_pol = 2'h0;
            end
            3'h6: begin
                // A out1 and B out2
                ph_pol = 2'h2;
            end
            default: begin
                // B out1 alone
                ph_on = 2'h2;
                ph_pol = 2'h0;
            end
        endcase
    end

    // Per-sink drive: bits 0 and 1 are phase A, bits 2 and 3 phase B
    // sink low when active
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sink
            // Even bits sink on polarity 0, odd bits on polarity 1
            logic pol_match;
            assign pol_match = (ph_pol[gi / 2] == 1'(gi % 2));
            assign sink_next_n[gi] = !(ph_on[gi / 2] && pol_match) || inh_in;
        end
    endgenerate

    // Sequencer next state
    always_comb begin
        next_q = q;
        // Step level kept for edge detection
        next_q.step_d = step_in;
        next_q.pos = pos_next;
        // zero flags
        // A flag follows the winding map even while inhibited, so software
        // still sees where the rotor will resume
        next_q.zero = ~ph_on;
        next_q.sink_n = sink_next_n;
        // trigger on phase change
        // Inhibit gates the trigger: a boost into windings that are off is wasted
        next_q.trig[0] = (sink_next_n[1:0] != q.sink_n[1:0]) && !inh_in;
        next_q.trig[1] = (sink_next_n[3:2] != q.sink_n[3:2]) && !inh_in;
    end

    // State register; reset leaves every sink off and the position at zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.sink_n <= 4'hF;
        end else begin
            q <= next_q;
        end
    end

    // One boost monostable per phase, both sharing the timing node
    // boost active high
    generate
        for (gi = 0; gi < 2; gi++) begin : g_mono
            boost_mono boost_mono_inst (
                .sys_clk_i(sys_clk_i),
                .rstn_i(rstn_i),
                .trigger_i(q.trig[gi]),
                .hold_i(hold_node),
                .boost_o(boost[gi])
            );
        end
    endgenerate

    assign link.driver_level_sel0 = q.zero[0];
    assign link.driver_level_sel1 = q.zero[1];
    assign link.phase_sink_n = q.sink_n;
    assign link.phase_a_boost_out = boost[0];
    assign link.phase_b_boost_out = boost[1];
    assign position_o = q.pos;

endmodule : phase_sequencer

// >>> step_source.sv
// Step source end: register-driven controller of the phase sequencer
module step_source
    import stepper_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic rstn_i, // Async reset, active low
    input wire logic [3:0] addr_i, // Register address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, cycle after strobe
    output logic irq_o, // Level interrupt
    stepper_link_if.source link // Link to sequencer
);

    typedef struct packed {
        logic [3:0] ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic irq;
        logic busy;
        logic step;
        logic [3:0] cnt;
        logic flags_d;
    } src_s;

    src_s q;
    src_s next_q;
    logic [2:0] ev;
    logic flags_clear;

    assign flags_clear = !link.driver_level_sel0 && !link.driver_level_sel1;

    always_comb begin
        next_q = q;
        ev = 3'h0;
        next_q.rdata = DATA_ZERO;
        // Step pulse timing, fixed high and low widths
        if (q.busy) begin
            if (q.cnt != 4'h0) begin
                next_q.cnt = q.cnt - 4'h1;
            end else if (q.step) begin
                next_q.step = 1'b0;
                next_q.cnt = STEP_LOW_CYCLES - 4'h1;
            end else begin
                next_q.busy = 1'b0;
                ev[IRQ_STEP_BIT] = 1'b1;
            end
        end
        next_q.flags_d = flags_clear;
        if (flags_clear && !q.flags_d) begin
            ev[IRQ_FULL_OK_BIT] = 1'b1;
        end
        // Register writes
        if (wr_i) begin
            if (addr_i == ADDR_CTRL) begin
                // full-step only from a two-winding state
                if (!wdata_i[CTRL_HALF_BIT] && q.ctrl[CTRL_HALF_BIT] && !flags_clear) begin
                    ev[IRQ_REFUSED_BIT] = 1'b1;
                    next_q.ctrl = {wdata_i[3:1], 1'b1};
                end else begin
                    next_q.ctrl = wdata_i[3:0];
                end
            end else if (addr_i == ADDR_CMD) begin
                if (wdata_i[CMD_STEP_BIT] && !q.busy) begin
                    next_q.busy = 1'b1;
                    next_q.step = 1'b1;
                    next_q.cnt = STEP_HIGH_CYCLES - 4'h1;
                end else if (wdata_i[CMD_STEP_BIT]) begin
                    ev[IRQ_REFUSED_BIT] = 1'b1;
                end
            end else if (addr_i == ADDR_IRQ_STAT) begin
                next_q.irq_stat = q.irq_stat & ~wdata_i[2:0];
            end else if (addr_i == ADDR_IRQ_MASK) begin
                next_q.irq_mask = wdata_i[2:0];
            end
        end
        // Set wins over clear
        next_q.irq_stat = next_q.irq_stat | ev;
        // Register reads
        if (rd_i) begin
            if (addr_i == ADDR_CTRL) begin
                next_q.rdata = {28'h0, q.ctrl};
            end else if (addr_i == ADDR_STATUS) begin
                next_q.rdata = {25'h0, link.phase_b_boost_out, link.phase_a_boost_out,
                    link.driver_level_sel1, link.driver_level_sel0, flags_clear,
                    q.step, q.busy};
            end else if (addr_i == ADDR_IRQ_STAT) begin
                next_q.rdata = {29'h0, q.irq_stat};
            end else if (addr_i == ADDR_IRQ_MASK) begin
                next_q.rdata = {29'h0, q.irq_mask};
            end else if (addr_i == ADDR_POS) begin
                next_q.rdata = {28'h0, link.phase_sink_n};
            end
        end
        next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
        end else begin
            q <= next_q;
        end
    end

    // inhibit driven high until software clears it
    assign link.step = q.step;
    assign link.reverse = q.ctrl[CTRL_REV_BIT];
    assign link.half_mode = q.ctrl[CTRL_HALF_BIT];
    assign link.inhibit = q.ctrl[CTRL_INH_BIT];
    assign link.boost_node_o = 1'b0;
    assign link.boost_node_oe = q.ctrl[CTRL_BOOST_HOLD_BIT];
    assign rdata_o = q.rdata;
    assign irq_o = q.irq;

endmodule : step_source

// >>> stepper_link_checker.sv
// Concurrent checks on the link between step source and phase sequencer
module stepper_link_checker (
    input wire logic sys_clk_i, // System clock
    input wire logic rstn_i, // Async reset, active low
    input wire logic step, // Step level
    input wire logic reverse, // Direction select
    input wire logic half_mode, // Half-step select
    input wire logic inhibit, // Inhibit, active high
    input wire logic boost_node_o, // Timing node drive value
    input wire logic boost_node_oe, // Timing node drive enable
    input wire logic [3:0] phase_sink_n, // Phase sinks, active low
    input wire logic phase_a_boost_out, // Boost A, active high
    input wire logic phase_b_boost_out, // Boost B, active high
    input wire logic driver_level_sel0, // Zero A flag
    input wire logic driver_level_sel1 // Zero B flag
);
    timeunit 1ns;
    timeprecision 1ns;

    // A held timing node stretches a boost, so idle checks leave it out
    wire logic node_held = boost_node_oe && !boost_node_o;
    wire logic any_boost = phase_a_boost_out || phase_b_boost_out;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // A step is taken on a rising step level while inhibit is low
    sequence step_taken;
        !step ##1 (step && !inhibit);
    endsequence
    // A step taken with inhibit already low, so the old sinks show a real state
    sequence step_clean;
        (!step && !inhibit) ##1 (step && !inhibit);
    endsequence
    // Long enough for a boost from a step or an inhibit release to run out
    sequence quiet_run;
        (!step && !node_held && !$fell(inhibit))[*6];
    endsequence

    chk_legal_sink: assert property (
        phase_sink_n inside {4'hA, 4'hD, 4'h9, 4'h7, 4'h5, 4'hE, 4'h6, 4'hB, 4'hF})
        else $error("phase sinks show an illegal pattern");
    chk_inhibit_off: assert property (inhibit ##1 inhibit |-> phase_sink_n == 4'hF)
        else $error("phase sinks active while inhibited");
    chk_zero_a_flag: assert property (
        !inhibit ##1 !inhibit |-> driver_level_sel0 == (phase_sink_n[1:0] == 2'b11))
        else $error("zero A flag disagrees with phase A sinks");
    chk_zero_b_flag: assert property (
        !inhibit ##1 !inhibit |-> driver_level_sel1 == (phase_sink_n[3:2] == 2'b11))
        else $error("zero B flag disagrees with phase B sinks");
    // Inhibit must be low a cycle earlier too, since its release moves the sinks
    chk_state_held: assert property (
        !inhibit ##1 (!inhibit && !$rose(step)) ##1 !inhibit |-> $stable(phase_sink_n))
        else $error("phase state moved without a step");
    chk_step_moves: assert property (
        step_taken |=> phase_sink_n != $past(phase_sink_n))
        else $error("step taken but phase state kept");
    chk_boost_fires: assert property (step_taken |-> ##[1:3] any_boost)
        else $error("no boost pulse after a step");
    chk_boost_idle: assert property (quiet_run |-> !any_boost)
        else $error("boost output stays on without a step");
    chk_boost_inhibit: assert property ((inhibit && !node_held)[*6] |-> !any_boost)
        else $error("boost output on while inhibited");
    chk_full_two_wind: assert property (
        step_clean ##0 !half_mode |=> phase_sink_n inside {4'hA, 4'h9, 4'h5, 4'h6})
        else $error("full step did not land on two windings");
    chk_half_alternate: assert property (
        step_clean ##0 half_mode |=> (phase_sink_n inside {4'hA, 4'h9, 4'h5, 4'h6})
            != ($past(phase_sink_n) inside {4'hA, 4'h9, 4'h5, 4'h6}))
        else $error("half step did not alternate winding count");
    chk_dir_from_home: assert property (
        step_clean ##0 (!half_mode && phase_sink_n == 4'hA)
            |=> phase_sink_n == ($past(reverse) ? 4'h6 : 4'h9))
        else $error("full step from home went the wrong way");
endmodule : stepper_link_checker

// >>> tb_unipolar_stepper_phase_sequencer.sv
// Testbench joining step source and phase sequencer through the link
`define CHECK(name, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("[FAIL] %s expected %h seen %h", name, exp, got); \
    end \
end

module tb_unipolar_stepper_phase_sequencer
    import stepper_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [2:0] position;
    logic [2:0] pos;
    logic [31:0] d;
    int bad_count = 0;
    int checked = 0;
    // Active-low sink patterns per phase index
    logic [3:0] sink_tab [0:7] = '{4'hA, 4'hD, 4'h9, 4'h7, 4'h5, 4'hE, 4'h6, 4'hB};

    stepper_link_if link_if ();

    step_source step_source_inst (.sys_clk_i(sys_clk), .rstn_i(rstn), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
        .link(link_if.source));
    phase_sequencer phase_sequencer_inst (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .link(link_if.sequencer), .position_o(position));
    stepper_link_checker stepper_link_checker_inst (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .step(link_if.step), .reverse(link_if.reverse), .half_mode(link_if.half_mode),
        .inhibit(link_if.inhibit), .boost_node_o(link_if.boost_node_o),
        .boost_node_oe(link_if.boost_node_oe), .phase_sink_n(link_if.phase_sink_n),
        .phase_a_boost_out(link_if.phase_a_boost_out),
        .phase_b_boost_out(link_if.phase_b_boost_out),
        .driver_level_sel0(link_if.driver_level_sel0),
        .driver_level_sel1(link_if.driver_level_sel1));

    // 10 MHz system clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : bus_rd

    // Polls the sticky done bit rather than busy, which may not be up yet
    task automatic do_step();
        logic [31:0] s;
        bus_wr(ADDR_CMD, 32'h1);
        s = 32'h0;
        for (int k = 0; k < 20 && s[0] !== 1'b1; k++) begin
            bus_rd(ADDR_IRQ_STAT, s);
        end
        `CHECK("step done", 1'b1, s[0])
        bus_wr(ADDR_IRQ_STAT, 32'h1);
    endtask : do_step

    // Generous bound: the whole sequence needs about 350 cycles
    initial begin
        #400000;
        bad_count++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        bus_rd(ADDR_CTRL, d);
        `CHECK("ctrl reset", 32'h4, d)
        `CHECK("sinks reset", 4'hF, link_if.phase_sink_n)
        bus_rd(4'hF, d);
        `CHECK("unmapped read", 32'h0, d)
        do_step();
        `CHECK("inhibited position", 3'h0, position)
        pos = 3'h0;
        // Modes: bit 0 half-step, bit 1 reverse
        for (int m = 0; m < 4; m++) begin
            bus_wr(ADDR_CTRL, 32'(m));
            repeat (m[0] ? 8 : 4) begin
                do_step();
                pos = m[1] ? pos - 3'(m[0] ? 1 : 2) : pos + 3'(m[0] ? 1 : 2);
                `CHECK("position", pos, position)
                `CHECK("sinks", sink_tab[pos], link_if.phase_sink_n)
                `CHECK("zero a", pos[1:0] == 2'b11, link_if.driver_level_sel0)
                `CHECK("zero b", pos[1:0] == 2'b01, link_if.driver_level_sel1)
            end
        end
        // Leaving half-step on a single-winding position is refused
        bus_wr(ADDR_CTRL, 32'h1);
        do_step();
        bus_wr(ADDR_IRQ_STAT, 32'h7);
        bus_wr(ADDR_CTRL, 32'h0);
        bus_rd(ADDR_CTRL, d);
        `CHECK("refused switch", 32'h1, d)
        bus_rd(ADDR_IRQ_STAT, d);
        `CHECK("refused flag", 1'b1, d[2])
        `CHECK("irq masked", 1'b0, irq)
        bus_wr(ADDR_IRQ_MASK, 32'h4);
        @(posedge sys_clk);
        #1 `CHECK("irq raised", 1'b1, irq)
        bus_wr(ADDR_IRQ_STAT, 32'h4);
        @(posedge sys_clk);
        #1 `CHECK("irq cleared", 1'b0, irq)
        // On two windings the switch to full-step is accepted
        do_step();
        bus_wr(ADDR_CTRL, 32'h0);
        bus_rd(ADDR_CTRL, d);
        `CHECK("accepted switch", 32'h0, d)
        do_step();
        `CHECK("full after half", 3'h4, position)
        bus_rd(ADDR_POS, d);
        `CHECK("sink readback", 32'h5, d)
        bus_rd(ADDR_STATUS, d);
        `CHECK("status idle", 32'h4, d)
        // A second step order while the first still runs is refused
        bus_wr(ADDR_IRQ_STAT, 32'h7);
        bus_wr(ADDR_CMD, 32'h1);
        bus_wr(ADDR_CMD, 32'h1);
        repeat (8) @(posedge sys_clk);
        bus_rd(ADDR_IRQ_STAT, d);
        `CHECK("busy refused", 3'h5, d[2:0])
        `CHECK("one step only", 3'h6, position)
        finish_test();
    end
endmodule : tb_unipolar_stepper_phase_sequencer
